// [include/osc_tune_pkg.sv]
// Package with register map, field layout and timing constants of the oscillator tuning block.
package osc_tune_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] TUNING_OFFSET   = 12'h000;
  localparam logic [11:0] CONTROL_OFFSET  = 12'h004;
  localparam logic [11:0] STATUS_OFFSET   = 12'h008;

  localparam int          TRIM_LSB        = 0;
  localparam int          TRIM_WIDTH      = 6;
  localparam int          SW_PLL_BIT      = 6;
  localparam int          LF_SRC_BIT      = 7;
  localparam logic [7:0]  TUNING_RESET    = 8'h00;

  localparam int          CTRL_CFG_PLL_BIT   = 0;
  localparam int          CTRL_TWO_SPEED_BIT = 1;
  localparam int          CTRL_MODE_LSB      = 2;
  localparam logic [3:0]  CONTROL_RESET      = 4'h0;
  localparam logic [6:0]  TRIM_LEVEL_RESET   = 7'h20;

  // ****************************************************************
  // Oscillator modes and timing
  // ****************************************************************
  localparam logic [1:0]  MODE_LOW_POWER_XTAL  = 2'h0;
  localparam logic [1:0]  MODE_STD_XTAL        = 2'h1;
  localparam logic [1:0]  MODE_HIGH_SPEED_XTAL = 2'h2;
  localparam logic [1:0]  MODE_EXT_CLOCK       = 2'h3;

  localparam int          OST_CYCLES      = 1024;
  localparam int          LF_DIVIDE       = 512;
  localparam int          PLL_FACTOR      = 4;
  localparam logic [2:0]  PLL_BYPASS_MULT = 3'h1;

  typedef struct packed {
    logic       por;
    logic       bor;
    logic       wake;
    logic       osc_enable;
    logic       powerup_timer_expired;
  } startup_events_t;

endpackage

// [hdl/osc_tune_and_startup_timer.sv]
// Oscillator tuning register, low-frequency source select, PLL enable and start-up timer.
`timescale 1ns/10ps
// Behaviour
// R01: Fast oscillator trim is a six-bit two's-complement value, reset to zero.
// R02: Every tuning register write starts moving the fast oscillator to the new trim.
// R03: Execution continues during the frequency move; no flag reports it.
// R04: Trim never touches the slow oscillator or anything timed from it.
// R05: Low source select set gives fast clock divided by 512, clear gives slow oscillator.
// R06: Software PLL enable turns the multiplier on; clearing it turns it off.
// R07: Trim 011111 is fastest; 000000 is the calibrated frequency.
// R08: Trim 100000 is slowest; codes map monotonically low to high.
// R09: Start-up timer expires only after 1024 external oscillator input edges.
// R10: Start-up timer applies only in the three crystal modes.
// R11: While the timer runs on the primary clock, the program counter is held.
// R12: Resets, wake, oscillator enable and power-up expiry each restart the timer.
// R13: A two-speed start-up mode lets code run before the timer expires.
// R14: Configuration PLL enable forces the multiplier on, else software decides.
// R15: The multiplier multiplies its input by four.
module osc_tune_and_startup_timer
  import osc_tune_pkg::*;
#(
  parameter int OST_COUNT = OST_CYCLES
)
(
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_OSC_INPUT_PIN,
  input  wire logic        SLOW_OSC_CLK_EN,
  input  wire logic        FAST_OSC_CLK_EN,
  input  wire logic        POR_EVENT,
  input  wire logic        BOR_EVENT,
  input  wire logic        WAKE_EVENT,
  input  wire logic        OSC_ENABLE_EVENT,
  input  wire logic        POWERUP_TIMER_EXPIRED,
  input  wire logic        SYSCLK_IS_PRIMARY,
  output logic [6:0]       FAST_OSC_TRIM_LEVEL,
  output logic             TRIM_UPDATE,
  output logic             LOW_FREQ_CLK_EN,
  output logic             PLL_ENABLE,
  output logic [2:0]       PLL_MULTIPLIER,
  output logic             OST_RUNNING,
  output logic             PC_HOLD
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  // One-hot codes keep the timer decode to a single bit per state.
  typedef enum logic [1:0]
  {
    TMR_IDLE     = 2'b01,
    TMR_COUNTING = 2'b10
  } tmr_state_t;

  typedef struct packed {
    logic [7:0]  tuning;
    logic [3:0]  control;
    tmr_state_t  tmr;
    logic [10:0] ost_count;
    logic        ost_running;
    logic        ext_prev;
    logic [8:0]  div_count;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [6:0]  trim_level;
    logic        trim_update;
    logic        low_clk_en;
    logic        pll_en;
    logic [2:0]  pll_mult;
    logic        pc_hold;
  } state_t;

  localparam state_t ST_RESET = '{
    tuning:     TUNING_RESET,
    control:    CONTROL_RESET,
    tmr:        TMR_IDLE,
    trim_level: TRIM_LEVEL_RESET,
    pll_mult:   PLL_BYPASS_MULT,
    default:    '0
  };

  state_t          st;
  state_t          next_st;
  startup_events_t ev;
  logic            setup;
  logic            wr_lane0;
  logic            wr_hit;
  logic [1:0]      mode;
  logic            xtal_mode;
  logic            any_event;
  logic            pin_rise;
  logic            last_edge;
  logic            div_wrap;
  logic [6:0]      new_trim_level;

  // ****************************************************************
  // Decoded conditions
  // ****************************************************************
  assign ev = '{por: POR_EVENT, bor: BOR_EVENT, wake: WAKE_EVENT,
                osc_enable: OSC_ENABLE_EVENT, powerup_timer_expired: POWERUP_TIMER_EXPIRED};
  assign setup = PSEL && !PENABLE;
  assign wr_lane0 = PWRITE && PSTRB[0];
  assign mode = st.control[CTRL_MODE_LSB +: 2];
  assign xtal_mode = (mode == MODE_LOW_POWER_XTAL) || (mode == MODE_STD_XTAL)
                  || (mode == MODE_HIGH_SPEED_XTAL); // R10
  assign any_event = (ev != '0);
  assign pin_rise = EXT_OSC_INPUT_PIN && !st.ext_prev;
  assign last_edge = (st.ost_count == 11'(OST_COUNT - 1));
  assign div_wrap = (st.div_count == 9'(LF_DIVIDE - 1));
  // Offset binary keeps the analog trim ladder monotonic: the sign bit is inverted.
  assign new_trim_level = {1'b0, ~PWDATA[TRIM_LSB + TRIM_WIDTH - 1],
                           PWDATA[TRIM_LSB +: TRIM_WIDTH - 1]};

  always_comb
  begin
    next_st = st;
    next_st.trim_update = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    wr_hit = 1'b0;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    // Registers answer one cycle after setup, so every access takes exactly two cycles.
    if (setup)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      if (PADDR == TUNING_OFFSET)
      begin
        next_st.prdata = {24'h00_0000, st.tuning};
        if (wr_lane0)
        begin
          next_st.tuning = PWDATA[7:0]; // R01
          wr_hit = 1'b1;
        end
      end
      else if (PADDR == CONTROL_OFFSET)
      begin
        next_st.prdata = {28'h000_0000, st.control};
        if (wr_lane0)
        begin
          next_st.control = PWDATA[3:0];
        end
      end
      else if (PADDR == STATUS_OFFSET)
      begin
        // The status word holds only what hardware sets, so a write to it is refused.
        next_st.prdata = {31'h0000_0000, st.ost_running};
        next_st.pslverr = PWRITE;
      end
      else
      begin
        next_st.pslverr = 1'b1;
      end
    end

    // ****************************************************************
    // Fast oscillator trim
    // ****************************************************************
    // Rewriting the same trim still pulses the update, so the analog slew restarts.
    if (wr_hit)
    begin
      next_st.trim_level = new_trim_level; // R07 R08
      next_st.trim_update = 1'b1; // R02 R03
    end

    // ****************************************************************
    // Low-frequency clock
    // ****************************************************************
    // With the low source select clear the low clock runs from the slow oscillator, untouched by the trim; when set it follows the trimmed fast clock.
    next_st.low_clk_en = 1'b0;
    if (st.tuning[LF_SRC_BIT])
    begin
      if (FAST_OSC_CLK_EN)
      begin
        if (div_wrap)
        begin
          next_st.div_count = 9'h000;
          next_st.low_clk_en = 1'b1; // R05
        end
        else
        begin
          next_st.div_count = st.div_count + 9'h001;
        end
      end
    end
    else
    begin
      next_st.div_count = 9'h000;
      next_st.low_clk_en = SLOW_OSC_CLK_EN; // R04 R05
    end

    // ****************************************************************
    // Frequency multiplier
    // ****************************************************************
    // Nothing here checks that the fast oscillator sits at its 8 MHz setting.
    next_st.pll_en = st.control[CTRL_CFG_PLL_BIT] || st.tuning[SW_PLL_BIT]; // R06 R14
    if (next_st.pll_en)
    begin
      next_st.pll_mult = 3'(PLL_FACTOR); // R15
    end
    else
    begin
      next_st.pll_mult = PLL_BYPASS_MULT;
    end

    // ****************************************************************
    // Start-up timer
    // ****************************************************************
    // The pin is sampled, so it must toggle slower than half the block clock.
    next_st.ext_prev = EXT_OSC_INPUT_PIN;
    case (st.tmr)
      TMR_IDLE:
      begin
        if (any_event && xtal_mode)
        begin
          next_st.tmr = TMR_COUNTING; // R12
          next_st.ost_count = 11'h000;
        end
      end
      TMR_COUNTING:
      begin
        if (!xtal_mode)
        begin
          next_st.tmr = TMR_IDLE; // R10
        end
        else if (any_event)
        begin
          next_st.ost_count = 11'h000; // R12
        end
        else if (pin_rise)
        begin
          if (last_edge)
          begin
            next_st.tmr = TMR_IDLE; // R09
          end
          else
          begin
            next_st.ost_count = st.ost_count + 11'h001;
          end
        end
      end
      default:
      begin
        next_st.tmr = TMR_IDLE;
      end
    endcase
    next_st.ost_running = (next_st.tmr == TMR_COUNTING);

    // ****************************************************************
    // Execution hold
    // ****************************************************************
    // Two-speed start-up leaves the timer running but lets code execute meanwhile.
    next_st.pc_hold = next_st.ost_running && SYSCLK_IS_PRIMARY
                   && !st.control[CTRL_TWO_SPEED_BIT]; // R11 R13
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      st <= ST_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a state flop, so no decode glitch reaches the analog side.
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign FAST_OSC_TRIM_LEVEL = st.trim_level;
  assign TRIM_UPDATE = st.trim_update;
  assign LOW_FREQ_CLK_EN = st.low_clk_en;
  assign PLL_ENABLE = st.pll_en;
  assign PLL_MULTIPLIER = st.pll_mult; // R15
  assign OST_RUNNING = st.ost_running;
  assign PC_HOLD = st.pc_hold;

endmodule

// [tb/osc_tune_assertions.sv]
// Concurrent checks on the ports of the oscillator tuning block.
`timescale 1ns/10ps
module osc_tune_checker
  import osc_tune_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        EXT_OSC_INPUT_PIN,
  input wire logic [6:0]  FAST_OSC_TRIM_LEVEL,
  input wire logic        TRIM_UPDATE,
  input wire logic        PLL_ENABLE,
  input wire logic [2:0]  PLL_MULTIPLIER,
  input wire logic        OST_RUNNING,
  input wire logic        PC_HOLD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  wire logic setup = PSEL && !PENABLE;
  wire logic twr = setup && PWRITE && PADDR == TUNING_OFFSET;
  a_trim_update: assert property (
    twr && PSTRB[0] |=> TRIM_UPDATE) else $error("trim update missing");
  a_update_cause: assert property (
    !twr |=> !TRIM_UPDATE) else $error("trim update without write");
  a_ready_next: assert property (
    setup |=> PREADY) else $error("no ready after setup");
  a_err_unmapped: assert property (
    setup && !PWRITE && PADDR > STATUS_OFFSET |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped read accepted");
  a_pll_mult: assert property (
    PLL_MULTIPLIER == (PLL_ENABLE ? 3'h4 : 3'h1)) else $error("bad multiplier");
  a_trim_bit6: assert property (
    !FAST_OSC_TRIM_LEVEL[6]) else $error("trim level out of range");
  a_trim_map: assert property (
    twr && PSTRB[0] |=> FAST_OSC_TRIM_LEVEL == {1'b0, ~$past(PWDATA[5]), $past(PWDATA[4:0])})
    else $error("trim level does not follow write");
  a_hold_running: assert property (
    PC_HOLD |-> OST_RUNNING) else $error("hold while idle");
  a_run_length: assert property (
    $rose(OST_RUNNING) |-> OST_RUNNING[*8]) else $error("timer ended early");
  a_stop_edge: assert property (
    $fell(OST_RUNNING) |-> $past(EXT_OSC_INPUT_PIN) && !$past(EXT_OSC_INPUT_PIN, 2))
    else $error("timer ended without pin edge");
  cover property (TRIM_UPDATE);
  cover property ($fell(OST_RUNNING));
  cover property (PC_HOLD);
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the oscillator tuning block.
`timescale 1ns/10ps
module tb_top;
  import osc_tune_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pin = 0, slow = 0, fast = 0;
  logic        prim = 0, pready, pslverr, tupd, lfen, config_pll_enable, run, hold, up, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [4:0]  ev = 0;
  logic [6:0]  lvl;
  logic [2:0]  mult;
  logic [7:0]  v;
  logic [7:0]  cor [4] = '{8'h1f, 8'h20, 8'h00, 8'h5f};
  int          n_mismatch = 0, num_checks = 0, cyc = 0, n;
  osc_tune_and_startup_timer #(.OST_COUNT(8)) dut (.MCLK(clk), .SYS_RST(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_OSC_INPUT_PIN(pin), .SLOW_OSC_CLK_EN(slow), .FAST_OSC_CLK_EN(fast),
    .POR_EVENT(ev[4]), .BOR_EVENT(ev[3]), .WAKE_EVENT(ev[2]),
    .OSC_ENABLE_EVENT(ev[1]), .POWERUP_TIMER_EXPIRED(ev[0]), .SYSCLK_IS_PRIMARY(prim),
    .FAST_OSC_TRIM_LEVEL(lvl), .TRIM_UPDATE(tupd), .LOW_FREQ_CLK_EN(lfen),
    .PLL_ENABLE(config_pll_enable), .PLL_MULTIPLIER(mult), .OST_RUNNING(run), .PC_HOLD(hold));
  always #5 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Ceiling sits well above the roughly 1300 cycles the tests need.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [6:0] exp_level(input logic [7:0] t);
    return {1'b0, ~t[5], t[4:0]};
  endfunction
  function automatic logic [3:0] exp_pll(input logic cfg, input logic [7:0] t);
    return {cfg | t[6], (cfg | t[6]) ? 3'h4 : 3'h1};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    up = tupd;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic tick(input int c);
    repeat (c)
    begin
      @(posedge clk);
      pin <= 1;
      @(posedge clk);
      pin <= 0;
    end
  endtask
  initial
  begin
    void'($urandom(32'h59cd7a35));
    repeat (16) @(posedge clk);
    rst <= 0;
    apb(0, TUNING_OFFSET, 0);
    chk(rd, 0);
    chk(lvl, exp_level(8'h00));
    apb(0, 12'h00c, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("test 1 done");
    for (int i = 0; i < 12; i++)
    begin
      v = i < 4 ? cor[i] : 8'($urandom);
      apb(1, TUNING_OFFSET, {24'h0, v});
      chk(up, 1);
      @(posedge clk);
      #1;
      chk(lvl, exp_level(v));
      chk({config_pll_enable, mult}, exp_pll(1'b0, v));
      apb(0, TUNING_OFFSET, 0);
      chk(rd, {24'h0, v});
    end
    apb(1, CONTROL_OFFSET, 1);
    apb(1, TUNING_OFFSET, 8'h3f);
    @(posedge clk);
    #1;
    chk({config_pll_enable, mult}, exp_pll(1'b1, 8'h3f));
    $display("test 2 done");
    @(posedge clk);
    slow <= 1;
    @(posedge clk);
    slow <= 0;
    #1;
    chk(lfen, 1);
    apb(1, TUNING_OFFSET, 8'h80);
    n = 0;
    fast <= 1;
    for (int c = 0; c < 1030; c++)
    begin
      @(posedge clk);
      n += lfen;
      if (c == 1023)
        fast <= 0;
    end
    chk(n, 2);
    $display("test 3 done");
    prim <= 1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1, CONTROL_OFFSET, (i == 5 ? 12 : (i % 3) * 4) + (i == 4 ? 2 : 0));
      @(posedge clk);
      ev <= 5'h10 >> (i % 5);
      @(posedge clk);
      ev <= 0;
      @(posedge clk);
      #1;
      chk({run, hold}, {i != 5, i < 4});
      apb(0, STATUS_OFFSET, 0);
      chk(rd, i != 5);
      tick(7);
      chk(run, i != 5);
      tick(1);
      @(posedge clk);
      #1;
      chk({run, hold}, 2'b00);
    end
    $display("test 4 done");
    end_sim();
  end
endmodule
bind osc_tune_and_startup_timer osc_tune_checker chk_i (.*);
